// file: rtl/cid_core.sv
// decode and execute unit for control, inherent and pointer-indirect instructions
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
// How it works
// - pc-changing instructions take two cycles, nop second
// - indirect access with pointer msb adds cycle
// - decode relative branch and branch by accumulator
// - decode call, jump, call by accumulator
// - decode literal return, return, interrupt return
// - sleep and watchdog clear update timeout/powerdown
// - option instruction copies accumulator to option
// - direction instruction copies accumulator to selected port
// - decode pointer add with pointer select bit
// - pointer add adds signed six-bit literal, flags kept
// - pointer arithmetic wraps modulo sixteen bits
// - indirect load with pre/post modify sets zero
// - indirect store with pre/post modify, flags kept
// - indexed load from pointer plus offset, zero
// - indexed store to pointer plus offset
// - literal and into accumulator, zero only
// - literal add sets carry, digit carry, zero
// - file and to accumulator or file, zero
module cid_core #(
  parameter int PC_W = 15,
  parameter int STACK_DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // instruction stream
  input wire logic instr_valid,
  input wire logic [13:0] instr,
  output logic instr_ready,
  output logic instr_done,
  output logic [1:0] instr_cycles,
  output logic [PC_W-1:0] program_counter,
  // data memory
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  input wire logic [7:0] mem_rdata,
  // register port
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  // core state
  output logic [7:0] accum,
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic zero_flag,
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic int_enable,
  output logic [7:0] option_value,
  output logic [63:0] port_direction_register,
  output logic sleep_req,
  output logic wdt_clear
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  initial begin
    if (PC_W < 12 || PC_W > 16) begin
      $error("cid_core: PC_W must be 12 to 16");
    end
    if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) begin
      $error("cid_core: STACK_DEPTH must be a power of two");
    end
  end

  typedef struct packed {
    cid_pkg::cid_state_e state;
    cid_pkg::cid_op_e op;
    logic [13:0] ins;
    logic [7:0] w;
    logic c;
    logic dcy;
    logic z;
    logic to;
    logic pdn;
    logic gie;
    logic [1:0][15:0] ptr;
    logic [PC_W-1:0] pc;
    logic [SP_W-1:0] sp;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
    logic [7:0] option;
    logic [7:0][7:0] pdir;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic mem_we;
    logic mem_re;
    logic ready;
    logic done;
    logic [1:0] cyc;
    logic xtra;
    logic sleep_req;
    logic wdt_clear;
    logic [31:0] rdata;
  } cid_state_s;

  cid_state_s r;
  cid_state_s n;
  logic [1:0] rsync_reg;
  logic rst_n;

  function automatic logic [15:0] sext6(input logic [5:0] k);
    return {{10{k[5]}}, k};
  endfunction

  function automatic logic [PC_W-1:0] sext9(input logic [8:0] k);
    return {{(PC_W-9){k[8]}}, k};
  endfunction

  function automatic logic is_two(input cid_pkg::cid_op_e op);
    case (op)
      cid_pkg::relative_branch_op, cid_pkg::branch_by_accum_op, cid_pkg::OP_CALL, cid_pkg::call_by_accum_op,
      cid_pkg::absolute_jump_op, cid_pkg::interrupt_return_op, cid_pkg::literal_return_op,
      cid_pkg::OP_RETURN: is_two = 1'b1;
      default: is_two = 1'b0;
    endcase
  endfunction

  function automatic cid_pkg::cid_op_e decode_op(input logic [13:0] i);
    if (i == cid_pkg::OPC_BR_ACC) return cid_pkg::branch_by_accum_op;
    if (i == cid_pkg::OPC_CALL_ACC) return cid_pkg::call_by_accum_op;
    if (i == cid_pkg::OPC_RET_INT) return cid_pkg::interrupt_return_op;
    if (i == cid_pkg::OPC_RETURN) return cid_pkg::OP_RETURN;
    if (i == cid_pkg::OPC_WDT_CLR) return cid_pkg::watchdog_clear_op;
    if (i == cid_pkg::OPC_OPTION) return cid_pkg::OP_OPTION;
    if (i == cid_pkg::OPC_SLEEP) return cid_pkg::OP_SLEEP;
    if (i[13:3] == cid_pkg::OPC_PORTDIR_13_3) return cid_pkg::OP_PORTDIR;
    if (i[13:3] == cid_pkg::OPC_IND_LOAD_13_3) return cid_pkg::indirect_load_op;
    if (i[13:3] == cid_pkg::OPC_IND_STORE_13_3) return cid_pkg::indirect_store_op;
    if (i[13:7] == cid_pkg::OPC_PTR_ADD_13_7) return cid_pkg::pointer_add_op;
    if (i[13:7] == cid_pkg::OPC_LOAD_IDX_13_7) return cid_pkg::OP_LOAD_IDX;
    if (i[13:7] == cid_pkg::OPC_STORE_IDX_13_7) return cid_pkg::OP_STORE_IDX;
    if (i[13:8] == cid_pkg::OPC_RET_LIT_13_8) return cid_pkg::literal_return_op;
    if (i[13:8] == cid_pkg::OPC_LIT_AND_13_8) return cid_pkg::literal_and_op;
    if (i[13:8] == cid_pkg::OPC_LIT_ADD_13_8) return cid_pkg::literal_add_op;
    if (i[13:8] == cid_pkg::OPC_FILE_AND_13_8) return cid_pkg::file_and_op;
    if (i[13:9] == cid_pkg::OPC_REL_BR_13_9) return cid_pkg::relative_branch_op;
    if (i[13:11] == cid_pkg::OPC_CALL_13_11) return cid_pkg::OP_CALL;
    if (i[13:11] == cid_pkg::OPC_JUMP_13_11) return cid_pkg::absolute_jump_op;
    return cid_pkg::OP_NOP;
  endfunction

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rsync_reg <= 2'h0;
    end else begin
      rsync_reg <= {rsync_reg[0], 1'b1};
    end
  end
  assign rst_n = rsync_reg[1];

  cid_pkg::cid_op_e op_in;
  logic sel_in;
  logic [15:0] p_in;
  logic [15:0] p_mod;
  logic [15:0] p_acc;
  logic [PC_W-1:0] pc1;
  logic [7:0] res;
  logic [8:0] sum9;
  logic [4:0] nib5;

  always_comb begin
    n = r;
    op_in = decode_op(instr);
    sel_in = 1'b0;
    p_in = 16'h0000;
    p_mod = 16'h0000;
    p_acc = 16'h0000;
    pc1 = r.pc + PC_W'(1);
    res = 8'h00;
    sum9 = 9'h000;
    nib5 = 5'h00;
    n.done = 1'b0;
    n.sleep_req = 1'b0;
    n.wdt_clear = 1'b0;
    n.mem_we = 1'b0;
    n.mem_re = 1'b0;
    n.rdata = 32'h0000_0000;
    if (bus_rd) begin
      case (bus_addr)
        cid_pkg::REG_ACCUM: n.rdata = {24'h00_0000, r.w};
        cid_pkg::REG_STATUS: n.rdata = {26'h000_0000, r.gie, r.to, r.pdn, r.z, r.dcy, r.c};
        cid_pkg::REG_PTR0: n.rdata = {16'h0000, r.ptr[0]};
        cid_pkg::REG_PTR1: n.rdata = {16'h0000, r.ptr[1]};
        cid_pkg::REG_PC: n.rdata = 32'(r.pc);
        cid_pkg::REG_OPTION: n.rdata = {24'h00_0000, r.option};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    // software writes first, so an instruction result in the same cycle wins
    if (bus_wr) begin
      case (bus_addr)
        cid_pkg::REG_ACCUM: n.w = bus_wdata[7:0];
        cid_pkg::REG_STATUS: begin
          n.c = bus_wdata[cid_pkg::ST_C];
          n.dcy = bus_wdata[cid_pkg::ST_DCY];
          n.z = bus_wdata[cid_pkg::ST_Z];
          n.pdn = bus_wdata[cid_pkg::ST_PDN];
          n.to = bus_wdata[cid_pkg::ST_TOUT];
          n.gie = bus_wdata[cid_pkg::ST_GIE];
        end
        cid_pkg::REG_PTR0: n.ptr[0] = bus_wdata[15:0];
        cid_pkg::REG_PTR1: n.ptr[1] = bus_wdata[15:0];
        cid_pkg::REG_PC: n.pc = bus_wdata[PC_W-1:0];
        cid_pkg::REG_OPTION: n.option = bus_wdata[7:0];
        default: n.w = n.w;
      endcase
    end
    case (r.state)
      cid_pkg::ST_IDLE: begin
        if (instr_valid) begin
          n.ins = instr;
          n.op = op_in;
          n.state = cid_pkg::ST_EXEC;
          n.xtra = 1'b0;
          sel_in = (op_in == cid_pkg::indirect_load_op || op_in == cid_pkg::indirect_store_op) ? instr[2] : instr[6];
          p_in = r.ptr[sel_in];
          case (op_in)
            cid_pkg::pointer_add_op: n.ptr[sel_in] = p_in + sext6(instr[5:0]);
            cid_pkg::indirect_load_op, cid_pkg::indirect_store_op: begin
              case (instr[1:0])
                cid_pkg::MM_PRE_INC: p_mod = p_in + 16'h0001;
                cid_pkg::MM_PRE_DEC: p_mod = p_in - 16'h0001;
                cid_pkg::MM_POST_INC: p_mod = p_in + 16'h0001;
                default: p_mod = p_in - 16'h0001;
              endcase
              p_acc = instr[1] ? p_in : p_mod;
              n.ptr[sel_in] = p_mod;
              n.mem_addr = p_acc;
              n.mem_re = (op_in == cid_pkg::indirect_load_op);
              n.mem_we = (op_in == cid_pkg::indirect_store_op);
              n.mem_wdata = r.w;
              n.xtra = p_acc[15];
            end
            cid_pkg::OP_LOAD_IDX, cid_pkg::OP_STORE_IDX: begin
              n.mem_addr = p_in + sext6(instr[5:0]);
              n.mem_re = (op_in == cid_pkg::OP_LOAD_IDX);
              n.mem_we = (op_in == cid_pkg::OP_STORE_IDX);
              n.mem_wdata = r.w;
              n.xtra = p_in[15];
            end
            cid_pkg::file_and_op: begin
              // a file address that names an indirect data port goes through its pointer
              if (instr[6:0] == cid_pkg::IND_PORT0_ADDR || instr[6:0] == cid_pkg::IND_PORT1_ADDR) begin
                p_acc = r.ptr[instr[0]];
                n.xtra = p_acc[15];
              end else begin
                p_acc = {9'h000, instr[6:0]};
              end
              n.mem_addr = p_acc;
              n.mem_re = 1'b1;
            end
            default: n.xtra = 1'b0;
          endcase
        end
      end
      cid_pkg::ST_EXEC: begin
        n.pc = pc1;
        case (r.op)
          cid_pkg::relative_branch_op: n.pc = pc1 + sext9(r.ins[8:0]);
          cid_pkg::branch_by_accum_op: n.pc = pc1 + PC_W'(r.w);
          cid_pkg::OP_CALL, cid_pkg::call_by_accum_op: begin
            // the stack wraps silently on overflow
            n.stack[r.sp] = pc1;
            n.sp = r.sp + SP_W'(1);
            n.pc = (r.op == cid_pkg::OP_CALL) ? {pc1[PC_W-1:11], r.ins[10:0]} : {pc1[PC_W-1:8], r.w};
          end
          cid_pkg::absolute_jump_op: n.pc = {pc1[PC_W-1:11], r.ins[10:0]};
          cid_pkg::interrupt_return_op, cid_pkg::literal_return_op, cid_pkg::OP_RETURN: begin
            n.sp = r.sp - SP_W'(1);
            n.pc = r.stack[n.sp];
            if (r.op == cid_pkg::literal_return_op) begin
              n.w = r.ins[7:0];
            end
            if (r.op == cid_pkg::interrupt_return_op) begin
              n.gie = 1'b1;
            end
          end
          cid_pkg::OP_SLEEP: begin
            n.to = 1'b1;
            n.pdn = 1'b0;
            n.sleep_req = 1'b1;
          end
          cid_pkg::watchdog_clear_op: begin
            n.to = 1'b1;
            n.pdn = 1'b1;
            n.wdt_clear = 1'b1;
          end
          cid_pkg::OP_OPTION: n.option = r.w;
          cid_pkg::OP_PORTDIR: n.pdir[r.ins[2:0]] = r.w;
          cid_pkg::indirect_load_op, cid_pkg::OP_LOAD_IDX: begin
            n.w = mem_rdata;
            n.z = (mem_rdata == 8'h00);
          end
          cid_pkg::literal_and_op: begin
            res = r.w & r.ins[7:0];
            n.w = res;
            n.z = (res == 8'h00);
          end
          cid_pkg::literal_add_op: begin
            sum9 = {1'b0, r.w} + {1'b0, r.ins[7:0]};
            nib5 = {1'b0, r.w[3:0]} + {1'b0, r.ins[3:0]};
            n.w = sum9[7:0];
            n.c = sum9[8];
            n.dcy = nib5[4];
            n.z = (sum9[7:0] == 8'h00);
          end
          cid_pkg::file_and_op: begin
            res = r.w & mem_rdata;
            n.z = (res == 8'h00);
            if (r.ins[7]) begin
              n.mem_we = 1'b1;
              n.mem_wdata = res;
            end else begin
              n.w = res;
            end
          end
          default: n.pc = pc1;
        endcase
        n.cyc = cid_pkg::CYC_ONE;
        if (r.xtra) begin
          n.state = cid_pkg::ST_XTRA;
        end else if (is_two(r.op)) begin
          n.state = cid_pkg::ST_NOP;
        end else begin
          n.state = cid_pkg::ST_IDLE;
          n.done = 1'b1;
        end
      end
      cid_pkg::ST_XTRA: begin
        n.cyc = r.cyc + 2'h1;
        if (is_two(r.op)) begin
          n.state = cid_pkg::ST_NOP;
        end else begin
          n.state = cid_pkg::ST_IDLE;
          n.done = 1'b1;
        end
      end
      cid_pkg::ST_NOP: begin
        n.cyc = r.cyc + 2'h1;
        n.state = cid_pkg::ST_IDLE;
        n.done = 1'b1;
      end
      default: n.state = cid_pkg::ST_IDLE;
    endcase
    n.ready = (n.state == cid_pkg::ST_IDLE);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.to <= cid_pkg::RST_TOUT;
      r.pdn <= cid_pkg::RST_PDN;
      r.ready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign instr_ready = r.ready;
  assign instr_done = r.done;
  assign instr_cycles = r.cyc;
  assign program_counter = r.pc;
  assign mem_addr = r.mem_addr;
  assign mem_wdata = r.mem_wdata;
  assign mem_we = r.mem_we;
  assign mem_re = r.mem_re;
  assign bus_rdata = r.rdata;
  assign accum = r.w;
  assign carry_flag = r.c;
  assign digit_carry_flag = r.dcy;
  assign zero_flag = r.z;
  assign timeout_flag = r.to;
  assign powerdown_flag = r.pdn;
  assign int_enable = r.gie;
  assign option_value = r.option;
  assign port_direction_register = r.pdir;
  assign sleep_req = r.sleep_req;
  assign wdt_clear = r.wdt_clear;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic exec_q;
  assign exec_q = (r.state == cid_pkg::ST_EXEC);

  property p_ctl_two;
    r.done && is_two(r.op) |-> r.cyc == cid_pkg::CYC_TWO;
  endproperty
  a_ctl_two: assert property (p_ctl_two) else $error("control op did not take two cycles");

  property p_ind_extra;
    exec_q && r.xtra && !is_two(r.op) |=> r.state == cid_pkg::ST_XTRA ##1 (r.done && r.cyc == cid_pkg::CYC_TWO);
  endproperty
  a_ind_extra: assert property (p_ind_extra) else $error("high pointer access lacks extra cycle");

  property p_rel_branch;
    exec_q && r.op == cid_pkg::relative_branch_op && !bus_wr |=>
      r.pc == $past(r.pc) + PC_W'(1) + sext9($past(r.ins[8:0]));
  endproperty
  a_rel_branch: assert property (p_rel_branch) else $error("relative branch target wrong");

  property p_call;
    exec_q && r.op == cid_pkg::OP_CALL |=> r.pc[10:0] == $past(r.ins[10:0]) && r.sp == $past(r.sp) + SP_W'(1);
  endproperty
  a_call: assert property (p_call) else $error("call target or stack wrong");

  property p_lit_return;
    exec_q && r.op == cid_pkg::literal_return_op |=> r.w == $past(r.ins[7:0]) && r.sp == $past(r.sp) - SP_W'(1);
  endproperty
  a_lit_return: assert property (p_lit_return) else $error("literal return wrong");

  property p_sleep;
    exec_q && r.op == cid_pkg::OP_SLEEP |=> r.to && !r.pdn && r.sleep_req ##1 !r.sleep_req;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flags wrong");

  property p_option;
    exec_q && r.op == cid_pkg::OP_OPTION |=> r.option == $past(r.w);
  endproperty
  a_option: assert property (p_option) else $error("option load wrong");

  property p_ptr_add;
    r.ready && instr_valid && decode_op(instr) == cid_pkg::pointer_add_op && !bus_wr |=>
      r.ptr[$past(instr[6])] == $past(r.ptr[instr[6]]) + sext6($past(instr[5:0])) && r.z == $past(r.z)
      && r.c == $past(r.c);
  endproperty
  a_ptr_add: assert property (p_ptr_add) else $error("pointer add wrong");

  property p_store_idx;
    r.ready && instr_valid && decode_op(instr) == cid_pkg::OP_STORE_IDX |=>
      r.mem_we && r.mem_wdata == $past(r.w) && r.mem_addr == $past(r.ptr[instr[6]] + sext6(instr[5:0]));
  endproperty
  a_store_idx: assert property (p_store_idx) else $error("indexed store wrong");

  property p_lit_add;
    exec_q && r.op == cid_pkg::literal_add_op |=>
      {r.c, r.w} == {1'b0, $past(r.w)} + {1'b0, $past(r.ins[7:0])} && r.z == (r.w == 8'h00);
  endproperty
  a_lit_add: assert property (p_lit_add) else $error("literal add wrong");

  property p_file_and;
    exec_q && r.op == cid_pkg::file_and_op && r.ins[7] |=>
      r.mem_we && r.mem_wdata == ($past(r.w) & $past(mem_rdata)) && r.w == $past(r.w);
  endproperty
  a_file_and: assert property (p_file_and) else $error("file and to file wrong");
endmodule

// file: rtl/cid_pkg.sv
// shared encodings, register map and constants for the control and indirect decoder
package cid_pkg;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_XTRA = 2'b10, ST_NOP = 2'b11} cid_state_e;
  typedef enum logic [4:0] {
    OP_NOP = 5'b00000, relative_branch_op = 5'b00001, branch_by_accum_op = 5'b00010, OP_CALL = 5'b00011,
    call_by_accum_op = 5'b00100, absolute_jump_op = 5'b00101, interrupt_return_op = 5'b00110,
    literal_return_op = 5'b00111, OP_RETURN = 5'b01000, watchdog_clear_op = 5'b01001, OP_SLEEP = 5'b01010,
    OP_OPTION = 5'b01011, OP_PORTDIR = 5'b01100, pointer_add_op = 5'b01101, indirect_load_op = 5'b01110,
    OP_LOAD_IDX = 5'b01111, indirect_store_op = 5'b10000, OP_STORE_IDX = 5'b10001, literal_and_op = 5'b10010,
    literal_add_op = 5'b10011, file_and_op = 5'b10100
  } cid_op_e;
  // full-word opcodes
  localparam logic [13:0] OPC_BR_ACC = 14'h000b;
  localparam logic [13:0] OPC_CALL_ACC = 14'h000a;
  localparam logic [13:0] OPC_RET_INT = 14'h0009;
  localparam logic [13:0] OPC_RETURN = 14'h0008;
  localparam logic [13:0] OPC_WDT_CLR = 14'h0064;
  localparam logic [13:0] OPC_OPTION = 14'h0062;
  localparam logic [13:0] OPC_SLEEP = 14'h0063;
  // prefix opcodes, compared against the top bits named in each
  localparam logic [4:0] OPC_REL_BR_13_9 = 5'h19;
  localparam logic [2:0] OPC_CALL_13_11 = 3'h4;
  localparam logic [2:0] OPC_JUMP_13_11 = 3'h5;
  localparam logic [5:0] OPC_RET_LIT_13_8 = 6'h34;
  localparam logic [10:0] OPC_PORTDIR_13_3 = 11'h00c;
  localparam logic [6:0] OPC_PTR_ADD_13_7 = 7'h62;
  localparam logic [10:0] OPC_IND_LOAD_13_3 = 11'h002;
  localparam logic [10:0] OPC_IND_STORE_13_3 = 11'h003;
  localparam logic [6:0] OPC_LOAD_IDX_13_7 = 7'h7e;
  localparam logic [6:0] OPC_STORE_IDX_13_7 = 7'h7f;
  localparam logic [5:0] OPC_LIT_AND_13_8 = 6'h39;
  localparam logic [5:0] OPC_LIT_ADD_13_8 = 6'h3e;
  localparam logic [5:0] OPC_FILE_AND_13_8 = 6'h05;
  // pre/post modifier codes
  localparam logic [1:0] MM_PRE_INC = 2'h0;
  localparam logic [1:0] MM_PRE_DEC = 2'h1;
  localparam logic [1:0] MM_POST_INC = 2'h2;
  localparam logic [1:0] MM_POST_DEC = 2'h3;
  // file addresses that alias the indirect data ports
  localparam logic [6:0] IND_PORT0_ADDR = 7'h00;
  localparam logic [6:0] IND_PORT1_ADDR = 7'h01;
  // register map, byte addresses
  localparam logic [7:0] REG_ACCUM = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PTR0 = 8'h08;
  localparam logic [7:0] REG_PTR1 = 8'h0c;
  localparam logic [7:0] REG_PC = 8'h10;
  localparam logic [7:0] REG_OPTION = 8'h14;
  // status register bit positions
  localparam int ST_C = 0;
  localparam int ST_DCY = 1;
  localparam int ST_Z = 2;
  localparam int ST_PDN = 3;
  localparam int ST_TOUT = 4;
  localparam int ST_GIE = 5;
  localparam logic RST_TOUT = 1'b1;
  localparam logic RST_PDN = 1'b1;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
endpackage

// file: tb/cid_core_tb_top.sv
// self-checking testbench for the control and indirect decode unit
`timescale 1ns/1ps
module cid_core_tb_top;
  typedef struct {logic [13:0] word; logic [1:0] cyc; logic [7:0] acc; logic [2:0] zdc_c;} cid_row_s;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic instr_valid = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic [7:0] bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0000_0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic instr_ready, instr_done, mem_we, mem_re, carry_flag, digit_carry_flag, zero_flag;
  logic timeout_flag, powerdown_flag, int_enable, sleep_req, wdt_clear;
  logic [1:0] instr_cycles;
  logic [14:0] program_counter;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata, accum, option_value;
  logic [31:0] bus_rdata;
  logic [63:0] port_direction_register;
  int err_count = 0;
  int total_checks = 0;
  // {mem_re, mem_we, sleep_req, wdt_clear} seen high during the last instruction
  logic [3:0] seen_strobes = 4'h0;
  // memory answers combinationally with a pattern derived from the address
  assign mem_rdata = mem_addr[7:0] ^ 8'ha5;
  // rows run in order; accumulator and flags carry over from row to row
  cid_row_s rows [17] = '{
    '{14'h393c, 2'h1, 8'h30, 3'h0},
    '{14'h390f, 2'h1, 8'h00, 3'h4},
    '{14'h3eff, 2'h1, 8'hff, 3'h0},
    '{14'h3e01, 2'h1, 8'h00, 3'h7},
    '{14'h0010, 2'h1, 8'hb4, 3'h3},
    '{14'h0013, 2'h1, 8'hb4, 3'h3},
    '{14'h3900, 2'h1, 8'h00, 3'h7},
    '{14'h0019, 2'h1, 8'h00, 3'h7},
    '{14'h313f, 2'h1, 8'h00, 3'h7},
    '{14'h3f02, 2'h1, 8'hb5, 3'h3},
    '{14'h2000, 2'h2, 8'hb5, 3'h3},
    '{14'h3442, 2'h2, 8'h42, 3'h3},
    '{14'h000a, 2'h2, 8'h42, 3'h3},
    '{14'h0008, 2'h2, 8'h42, 3'h3},
    '{14'h000b, 2'h2, 8'h42, 3'h3},
    '{14'h0009, 2'h2, 8'h42, 3'h3},
    '{14'h0520, 2'h1, 8'h00, 3'h7}
  };

  cid_core uut (
    .clk(clk), .resetn(resetn), .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
    .instr_done(instr_done), .instr_cycles(instr_cycles), .program_counter(program_counter),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .accum(accum), .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag),
    .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag), .int_enable(int_enable),
    .option_value(option_value), .port_direction_register(port_direction_register),
    .sleep_req(sleep_req), .wdt_clear(wdt_clear)
  );

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // tasks start and end at a rising edge; strobes drop one edge before the next request
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic bus_read(input logic [7:0] a, input logic [31:0] exp);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    check_val(bus_rdata, exp, "bus read");
    @(posedge clk);
  endtask

  // edges from the take edge to the done cycle equal the cycle count
  task automatic exec(input logic [13:0] w, input logic [1:0] cyc);
    int n;
    instr <= w;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    seen_strobes = {mem_re, mem_we, sleep_req, wdt_clear};
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      seen_strobes = seen_strobes | {mem_re, mem_we, sleep_req, wdt_clear};
    end while (instr_done !== 1'b1 && n < 8);
    check_val(instr_cycles, {30'h0, cyc}, "cycles");
    check_val(n, {30'h0, cyc}, "latency");
    @(posedge clk);
  endtask

  initial begin
    repeat (4000) @(posedge clk);
    err_count++;
    $display("unexpected at %0t: run did not finish", $time);
    give_verdict();
  end

  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check_val({instr_ready, timeout_flag, powerdown_flag, accum}, 32'h0000_0700, "reset state");
    bus_write(cid_pkg::REG_ACCUM, 32'h0000_00f0);
    bus_write(cid_pkg::REG_PTR0, 32'h0000_0010);
    foreach (rows[i]) begin
      exec(rows[i].word, rows[i].cyc);
      check_val(accum, rows[i].acc, "accum");
      check_val({zero_flag, digit_carry_flag, carry_flag}, rows[i].zdc_c, "flags");
    end
    check_val(int_enable, 32'h0000_0001, "interrupt enable");
    // pointer with its top bit set costs one more cycle
    bus_write(cid_pkg::REG_PTR1, 32'h0000_8000);
    exec(14'h3fc0, 2'h2);
    check_val({mem_addr, mem_wdata}, 32'h0080_0000, "indexed store");
    check_val(seen_strobes, 32'h0000_0004, "store strobe");
    bus_write(cid_pkg::REG_PTR1, 32'h0000_ffff);
    exec(14'h3141, 2'h1);
    bus_read(cid_pkg::REG_PTR1, 32'h0000_0000);
    bus_write(cid_pkg::REG_PC, 32'h0000_0800);
    exec(14'h2923, 2'h2);
    check_val(program_counter, 32'h0000_0923, "jump target");
    exec(14'h33ff, 2'h2);
    check_val(program_counter, 32'h0000_0923, "branch back one");
    bus_write(cid_pkg::REG_ACCUM, 32'h0000_005c);
    exec(14'h0062, 2'h1);
    check_val(option_value, 32'h0000_005c, "option");
    exec(14'h0065, 2'h1);
    check_val(port_direction_register[47:40], 32'h0000_005c, "direction");
    // clear the status flags first so that timeout, and after watchdog clear also powerdown, must really be set
    bus_write(cid_pkg::REG_STATUS, 32'h0000_0000);
    exec(14'h0063, 2'h1);
    check_val({timeout_flag, powerdown_flag}, 32'h0000_0002, "standby flags");
    check_val(seen_strobes, 32'h0000_0002, "standby strobe");
    bus_write(cid_pkg::REG_STATUS, 32'h0000_0000);
    exec(14'h0064, 2'h1);
    check_val({timeout_flag, powerdown_flag}, 32'h0000_0003, "watchdog flags");
    check_val(seen_strobes, 32'h0000_0001, "watchdog strobe");
    exec(14'h05a0, 2'h1);
    check_val({accum, mem_wdata}, 32'h0000_5c04, "file and to f");
    check_val(seen_strobes, 32'h0000_000c, "file and strobes");
    bus_read(8'hfc, 32'h0000_0000);
    give_verdict();
  end
endmodule
